// file: shared/pulse_timer_defs.vh
// Constants for the six-channel externally triggered pulse timer.
// Assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
`ifndef PULSE_TIMER_DEFS_VH
`define PULSE_TIMER_DEFS_VH

// Clock and count-time conversion
`define CLK_PERIOD_PS 10000
`define CLK_RATE_MHZ 100
`define MIN_PULSE_WIDTH_NS 50
`define MIN_PULSE_WIDTH_CYC ((`MIN_PULSE_WIDTH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Global register byte offsets
`define OFF_COUNT_START 12'h000
`define OFF_SYNC_SELECT 12'h004
`define OFF_IRQ_STATUS 12'h008
`define OFF_IRQ_MASK 12'h00c
// Channel blocks
`define OFF_CH_BASE 12'h040
`define CH_STRIDE_LOG2 5
`define OFF_CH_CONTROL 3'h0
`define OFF_CH_MODE 3'h1
`define OFF_CH_IO 3'h2
`define OFF_CH_COUNT 3'h3
`define OFF_CH_REG_A 3'h4
`define OFF_CH_REG_B 3'h5
`define OFF_CH_REG_C 3'h6
`define OFF_CH_REG_D 3'h7

// Channel control fields
`define CTL_CLR_LSB 0
`define CTL_PRESC_LSB 2
`define CLR_NONE 2'h0
`define CLR_BY_A 2'h1
`define CLR_BY_B 2'h2
`define CLR_SYNC 2'h3
// Mode fields
`define MODE_PWM1_BIT 0
`define MODE_BUF_A_BIT 1
`define MODE_BUF_B_BIT 2
// I/O control fields
`define IO_CAP_A_BIT 0
`define IO_ACT_B_LSB 1
`define IO_ACT_D_LSB 3
`define ACT_HOLD 2'h0
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3

// Reset values
`define RST_CONTROL 6'h00
`define RST_MODE 3'h0
`define RST_IO 5'h00
`define RST_COUNT 16'h0000
`define RST_GENERAL 16'hffff

`endif

// file: rtl/pin_sync.v
// Three-stage synchroniser for pin inputs with an agreement filter.
// Assumes the inputs are asynchronous to clk; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 6
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1 feeds only stage 2; idle pins assumed high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= {WIDTH{1'b1}};
      s2_q <= {WIDTH{1'b1}};
      s3_q <= {WIDTH{1'b1}};
      level_q <= {WIDTH{1'b1}};
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) level_q[i] <= s3_q[i]; // Ignores single-cycle glitches
      end
    end
  end

endmodule // pin_sync

// file: rtl/timer_channel.v
// One 16-bit timer channel: counter, four general registers, capture, compare outputs.
// Assumes the top supplies the count enable, sync clear and register write strobes.
`timescale 1ns/1ps
`include "pulse_timer_defs.vh"
module timer_channel (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire cap_fall,
  input wire sync_clr,
  input wire [1:0] clr_src,
  input wire pwm1,
  input wire buf_a,
  input wire buf_b,
  input wire cap_en,
  input wire [1:0] act_b,
  input wire [1:0] act_d,
  input wire wr_en,
  input wire [2:0] wr_sel,
  input wire [15:0] wr_data,
  output reg [15:0] cnt_q,
  output reg [15:0] a_q,
  output reg [15:0] b_q,
  output reg [15:0] c_q,
  output reg [15:0] d_q,
  output wire [3:0] events,
  output wire clr_req,
  output reg out_ab_q,
  output reg out_cd_q
);

  reg clr_pend_q;
  wire cap;
  wire match_a;
  wire match_b;
  wire match_c;
  wire match_d;
  wire ev_a;

  function apply_act;
    input cur;
    input [1:0] act;
    begin
      case (act)
        `ACT_LOW: apply_act = 1'b0;
        `ACT_HIGH: apply_act = 1'b1;
        `ACT_TOGGLE: apply_act = ~cur;
        default: apply_act = cur;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare only on a count edge; buffer registers never compare
  assign cap = cap_en & cap_fall;
  assign match_a = tick & ~cap_en & (cnt_q == a_q);
  assign match_b = tick & (cnt_q == b_q);
  assign match_c = tick & ~buf_a & (cnt_q == c_q);
  assign match_d = tick & ~buf_b & (cnt_q == d_q);
  assign ev_a = cap | match_a;
  assign events = {match_d, match_c, match_b, ev_a};
  // Own clear source, also offered to the sync group
  assign clr_req = ((clr_src == `CLR_BY_A) & ev_a) | ((clr_src == `CLR_BY_B) & match_b);

  ////////////////////////////////////////////////////////////////////////////
  // Counter; a clear is held until the next count edge, then loads zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `RST_COUNT;
      clr_pend_q <= 1'b0;
    end else begin
      if (wr_en && wr_sel == `OFF_CH_COUNT) begin
        cnt_q <= wr_data;
      end else if (tick) begin
        cnt_q <= clr_pend_q ? 16'h0000 : cnt_q + 16'h0001;
      end
      if (clr_req | ((clr_src == `CLR_SYNC) & sync_clr)) begin
        clr_pend_q <= 1'b1;
      end else if (tick) begin
        clr_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General registers; hardware updates win over a software write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      a_q <= `RST_GENERAL;
      b_q <= `RST_GENERAL;
      c_q <= `RST_GENERAL;
      d_q <= `RST_GENERAL;
    end else begin
      if (cap) a_q <= cnt_q;
      else if (buf_a & match_a) a_q <= c_q;
      else if (wr_en && wr_sel == `OFF_CH_REG_A) a_q <= wr_data;
      if (buf_b & match_b) b_q <= d_q;
      else if (wr_en && wr_sel == `OFF_CH_REG_B) b_q <= wr_data;
      if (wr_en && wr_sel == `OFF_CH_REG_C) c_q <= wr_data;
      if (wr_en && wr_sel == `OFF_CH_REG_D) d_q <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins: PWM mode 1 pairs, or per-register action in normal mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ab_q <= 1'b0;
      out_cd_q <= 1'b0;
    end else if (pwm1) begin
      if (match_b) out_ab_q <= 1'b1;
      else if (match_a) out_ab_q <= 1'b0;
      if (match_d) out_cd_q <= 1'b1;
      else if (match_c) out_cd_q <= 1'b0;
    end else begin
      if (match_b) out_ab_q <= apply_act(out_ab_q, act_b);
      if (match_d) out_cd_q <= apply_act(out_cd_q, act_d);
    end
  end

endmodule // timer_channel

// file: rtl/pulse_timer_unit.v
// Six-channel 16-bit pulse timer with AHB-Lite register slave.
// Assumes one 100 MHz clock, asynchronous capture pins, an external DMA unit.
//
// Summary of operation
// - Channel 0 counter clears on each register A input capture.
// - Sync-clear channels clear together with the channel raising the clear.
// - Sync select bits group channels for common preset and clear.
// - PWM mode 1: first register of pair drives 0, second drives 1.
// - Second compare register holds pulse delay count after the falling edge.
// - Paired compare register ends the pulse, fixing its width.
// - Buffered mode copies buffer register into general register on compare match.
// - Channel 0 input capture raises a DMA transfer request.
// - One-shot: A captures falling edge, B compare match toggles output.
// - B holds delay buffered by D; C marks pulse disable count.
// - C match sets its flag, interrupts when enabled; handler clears it.
// - DMA channels write prepared words into delay and I/O registers.
// - Time equals count times clock period times input division.
// - Start register starts or stops selected counters together.
`timescale 1ns/1ps
`include "pulse_timer_defs.vh"
module pulse_timer_unit (
  input wire CLOCK,
  input wire RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  input wire [5:0] CAPTURE_IN,
  output wire [5:0] OUT_AB,
  output wire [5:0] OUT_CD,
  output wire IRQ,
  output reg DMA_REQ
);

  // Global state
  reg [5:0] start_q;
  reg [5:0] sync_q;
  reg [23:0] status_q;
  reg [23:0] mask_q;
  reg [5:0] presc_q;
  reg [5:0] ctl_q [0:5];
  reg [2:0] mode_q [0:5];
  reg [4:0] io_q [0:5];

  // Bus and capture edge state
  reg wr_pend_q;
  reg rd_pend_q;
  reg [11:0] addr_q;
  wire addr_phase;
  wire [5:0] pin_level;
  reg [5:0] pin_prev_q;
  wire [5:0] cap_fall;

  // Channel wiring
  wire [15:0] cnt_w [0:5];
  wire [15:0] a_w [0:5];
  wire [15:0] b_w [0:5];
  wire [15:0] c_w [0:5];
  wire [15:0] d_w [0:5];
  wire [23:0] events;
  wire [5:0] clr_req;
  wire [5:0] tick;
  wire group_clr;
  wire [5:0] ch_wr;
  wire cnt_preset;
  wire [2:0] wr_sel;
  reg [31:0] rd_mux;

  // Channel index of a byte address, 7 when not a channel block
  function [2:0] ch_of;
    input [11:0] a;
    reg [11:0] off;
    begin
      off = a - `OFF_CH_BASE;
      if (a >= `OFF_CH_BASE && a < `OFF_CH_BASE + 12'h0c0) begin
        ch_of = off[`CH_STRIDE_LOG2 +: 3]; // Six blocks only, so three bits suffice
      end else begin
        ch_of = 3'h7;
      end
    end
  endfunction

  // Register slot within a channel block
  function [2:0] slot_of;
    input [11:0] a;
    begin
      slot_of = a[4:2];
    end
  endfunction

  // Count enable for a prescale select: 1, 4, 16 or 64 clocks
  function div_en;
    input [1:0] sel;
    input [5:0] pc;
    begin
      case (sel)
        2'h0: div_en = 1'b1;
        2'h1: div_en = (pc[1:0] == 2'h0);
        2'h2: div_en = (pc[3:0] == 4'h0);
        default: div_en = (pc == 6'h00);
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero-wait, reads one wait state for a registered HRDATA
  assign addr_phase = HSEL & HTRANS[1] & HREADY;
  assign HREADYOUT = ~rd_pend_q;
  assign HRESP = 1'b0;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
      HRDATA <= 32'h00000000;
    end else begin
      if (rd_pend_q) begin
        HRDATA <= rd_mux;
        rd_pend_q <= 1'b0;
      end else begin
        wr_pend_q <= addr_phase & HWRITE;
        rd_pend_q <= addr_phase & ~HWRITE;
        if (addr_phase) addr_q <= {HADDR[11:2], 2'b00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture pins pass the three-stage filter, then falling edges are found
  pin_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk(CLOCK),
    .rst(RST),
    .pin(CAPTURE_IN),
    .level_q(pin_level)
  );

  assign cap_fall = pin_prev_q & ~pin_level;

  // Prescaler, shared so synchronised channels count on the same edges
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pin_prev_q <= 6'h3f;
      presc_q <= 6'h00;
    end else begin
      pin_prev_q <= pin_level;
      presc_q <= presc_q + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global registers; status flags are sticky and set beats clear
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      start_q <= 6'h00;
      sync_q <= 6'h00;
      status_q <= 24'h000000;
      mask_q <= 24'h000000;
    end else begin
      if (wr_pend_q && addr_q == `OFF_COUNT_START) start_q <= HWDATA[5:0];
      if (wr_pend_q && addr_q == `OFF_SYNC_SELECT) sync_q <= HWDATA[5:0];
      if (wr_pend_q && addr_q == `OFF_IRQ_MASK) mask_q <= HWDATA[23:0];
      if (wr_pend_q && addr_q == `OFF_IRQ_STATUS) begin
        status_q <= (status_q & ~HWDATA[23:0]) | events;
      end else begin
        status_q <= status_q | events;
      end
    end
  end

  assign IRQ = |(status_q & mask_q);

  // DMA request on every channel 0 capture; one pulse per event
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      DMA_REQ <= 1'b0;
    end else begin
      DMA_REQ <= cap_fall[0] & io_q[0][`IO_CAP_A_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel configuration registers
  assign wr_sel = slot_of(addr_q);
  assign cnt_preset = wr_pend_q && wr_sel == `OFF_CH_COUNT && ch_of(addr_q) != 3'h7
                      && sync_q[ch_of(addr_q)];

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : ch
      // A preset of one grouped counter presets the whole group
      assign ch_wr[g] = wr_pend_q && ((ch_of(addr_q) == g)
                        || (cnt_preset && sync_q[g]));
      // Start gating with prescale; count period scales time per count
      assign tick[g] = start_q[g] & div_en(ctl_q[g][`CTL_PRESC_LSB +: 2], presc_q);

      always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          ctl_q[g] <= `RST_CONTROL;
          mode_q[g] <= `RST_MODE;
          io_q[g] <= `RST_IO;
        end else if (wr_pend_q && ch_of(addr_q) == g) begin
          if (wr_sel == `OFF_CH_CONTROL) ctl_q[g] <= HWDATA[5:0];
          if (wr_sel == `OFF_CH_MODE) mode_q[g] <= HWDATA[2:0];
          if (wr_sel == `OFF_CH_IO) io_q[g] <= HWDATA[4:0];
        end
      end

      timer_channel u_ch (
        .clk(CLOCK),
        .rst(RST),
        .tick(tick[g]),
        .cap_fall(cap_fall[g]),
        .sync_clr(group_clr & sync_q[g]),
        .clr_src(ctl_q[g][`CTL_CLR_LSB +: 2]),
        .pwm1(mode_q[g][`MODE_PWM1_BIT]),
        .buf_a(mode_q[g][`MODE_BUF_A_BIT]),
        .buf_b(mode_q[g][`MODE_BUF_B_BIT]),
        .cap_en(io_q[g][`IO_CAP_A_BIT]),
        .act_b(io_q[g][`IO_ACT_B_LSB +: 2]),
        .act_d(io_q[g][`IO_ACT_D_LSB +: 2]),
        .wr_en(ch_wr[g]),
        .wr_sel(wr_sel),
        .wr_data(HWDATA[15:0]),
        .cnt_q(cnt_w[g]),
        .a_q(a_w[g]),
        .b_q(b_w[g]),
        .c_q(c_w[g]),
        .d_q(d_w[g]),
        .events(events[4*g +: 4]),
        .clr_req(clr_req[g]),
        .out_ab_q(OUT_AB[g]),
        .out_cd_q(OUT_CD[g])
      );
    end
  endgenerate

  // Clear raised by any grouped channel reaches every sync-clear member
  assign group_clr = |(clr_req & sync_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always @* begin
    rd_mux = 32'h00000000;
    case (addr_q)
      `OFF_COUNT_START: rd_mux = {26'h0000000, start_q};
      `OFF_SYNC_SELECT: rd_mux = {26'h0000000, sync_q};
      `OFF_IRQ_STATUS: rd_mux = {8'h00, status_q};
      `OFF_IRQ_MASK: rd_mux = {8'h00, mask_q};
      default: begin
        if (ch_of(addr_q) != 3'h7) begin
          case (slot_of(addr_q))
            `OFF_CH_CONTROL: rd_mux = {26'h0000000, ctl_q[ch_of(addr_q)]};
            `OFF_CH_MODE: rd_mux = {29'h00000000, mode_q[ch_of(addr_q)]};
            `OFF_CH_IO: rd_mux = {27'h0000000, io_q[ch_of(addr_q)]};
            `OFF_CH_COUNT: rd_mux = {16'h0000, cnt_w[ch_of(addr_q)]};
            `OFF_CH_REG_A: rd_mux = {16'h0000, a_w[ch_of(addr_q)]};
            `OFF_CH_REG_B: rd_mux = {16'h0000, b_w[ch_of(addr_q)]};
            `OFF_CH_REG_C: rd_mux = {16'h0000, c_w[ch_of(addr_q)]};
            default: rd_mux = {16'h0000, d_w[ch_of(addr_q)]};
          endcase
        end
      end
    endcase
  end

endmodule // pulse_timer_unit

// file: tb/pulse_timer_checker.sv
// Checker for the pulse timer: bus handshake, DMA request and interrupt masking.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pulse_timer_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [5:0] CAPTURE_IN,
  input wire logic IRQ,
  input wire logic DMA_REQ
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  wire rd_take = HSEL & HTRANS[1] & HREADY & ~HWRITE;
  wire wr_take = HSEL & HTRANS[1] & HREADY & HWRITE;
  logic mask_wr_q;
  logic [7:0] fall_age_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Mask write pending, so its data phase can be judged
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mask_wr_q <= 1'b0;
    end else if (HREADY) begin
      mask_wr_q <= wr_take && HADDR[11:0] == 12'h00c;
    end
  end
  // Age of last reference fall; saturates so stale edges never excuse a request
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      fall_age_q <= 8'hff;
    end else if ($fell(CAPTURE_IN[0])) begin
      fall_age_q <= 8'h0;
    end else if (fall_age_q != 8'hff) begin
      fall_age_q <= fall_age_q + 8'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_okay;
    HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_read_wait;
    rd_take |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_write_ready;
    wr_take |=> HREADYOUT;
  endproperty
  a_write_ready: assert property (p_write_ready) else $error("write stalled");
  property p_wait_cause;
    !HREADYOUT |-> $past(rd_take);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stray wait state");
  property p_rdata_hold;
    $changed(HRDATA) |-> $past(!HREADYOUT);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_dma_single;
    DMA_REQ |=> !DMA_REQ;
  endproperty
  a_dma_single: assert property (p_dma_single) else $error("long DMA request");
  property p_dma_cause;
    DMA_REQ |-> fall_age_q >= 8'd1 && fall_age_q <= 8'd10;
  endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("DMA without edge");
  property p_mask_off;
    mask_wr_q && HWDATA[23:0] == 24'h0 |=> !IRQ;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq high");
  c_dma: cover property (DMA_REQ);
  c_read: cover property (rd_take);
  c_irq: cover property ($rose(IRQ));
endmodule // pulse_timer_checker

bind pulse_timer_unit pulse_timer_checker u_checker (
  .CLOCK(CLOCK),
  .RST(RST),
  .HSEL(HSEL),
  .HADDR(HADDR),
  .HTRANS(HTRANS),
  .HWRITE(HWRITE),
  .HWDATA(HWDATA),
  .HREADY(HREADY),
  .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT),
  .HRESP(HRESP),
  .CAPTURE_IN(CAPTURE_IN),
  .IRQ(IRQ),
  .DMA_REQ(DMA_REQ)
);

// file: tb/ref_pulse_source.sv
// Reference pulse source driving the capture pins of the pulse timer.
// Assumes fire is a one-cycle request driven just after a rising edge.
`timescale 1ns/1ps
module ref_pulse_source (
  input wire logic clk,
  input wire logic fire,
  input wire logic [7:0] low_len,
  output logic [5:0] pins
);
  logic [7:0] left_q = 8'h0;
  // Low phase length; a request during a low phase is dropped
  always @(posedge clk) begin
    if (fire && left_q == 8'h0) begin
      left_q <= low_len;
    end else if (left_q != 8'h0) begin
      left_q <= left_q - 8'h1;
    end
  end
  // Idle pins rest at the pull-up level; only bit 0 carries the falling edge
  assign pins = {5'h1f, left_q == 8'h0};
endmodule // ref_pulse_source

// file: tb/ext_triggered_pulse_timer_bench.sv
// Self-checking bench for the six-channel pulse timer over AHB-Lite.
// Assumes the timer top, its bound checker and the reference pulse source.
`timescale 1ns/1ps
`define CHK(got, want) begin checks++; if ((got) !== (want)) begin bad_count++; \
  $display("wrong value at %0t: got %0h want %0h", $time, (got), (want)); end end
module ext_triggered_pulse_timer_bench;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [2:0] HSIZE = 3'h2;
  logic fire = 1'b0;
  logic [7:0] low_len = 8'h3;
  wire [31:0] HRDATA;
  wire HREADYOUT;
  wire HRESP;
  wire IRQ;
  wire DMA_REQ;
  wire [5:0] CAPTURE_IN;
  wire [5:0] OUT_AB;
  wire [5:0] OUT_CD;
  int bad_count = 0;
  int checks = 0;
  int r0, f0, r2, f2, rc, fc, dma_n;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [31:0] rnd;
  logic rd_dph = 1'b0;
  // Setup: ch0 capture-cleared toggle output with B buffered by D, ch2 PWM mode 1
  // One-shot delay 0x70 counts keeps above 1 us at 10 ns per count; width 0x40 counts
  logic [11:0] cfg_a [15] = '{12'h004, 12'h040, 12'h044, 12'h048, 12'h054, 12'h05c,
    12'h058, 12'h080, 12'h084, 12'h090, 12'h094, 12'h098, 12'h09c, 12'h00c, 12'h04c};
  logic [15:0] cfg_d [15] = '{16'h3f, 16'h1, 16'h4, 16'h7, 16'h70, 16'hb0, 16'hc0,
    16'h3, 16'h1, 16'h80, 16'h40, 16'h50, 16'h30, 16'h4, 16'h100};
  ////////////////////////////////////////////////////////////////////////////////
  always #5 CLOCK = ~CLOCK;
  pulse_timer_unit DUT (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CAPTURE_IN(CAPTURE_IN), .OUT_AB(OUT_AB), .OUT_CD(OUT_CD), .IRQ(IRQ),
    .DMA_REQ(DMA_REQ));
  ref_pulse_source src (.clk(CLOCK), .fire(fire), .low_len(low_len), .pins(CAPTURE_IN));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  // One single transfer; each phase waits for ready under a bound
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    begin
      n = 0;
      HSEL <= 1'b1;
      HADDR <= {20'h0, a};
      HWRITE <= w;
      HTRANS <= 2'h2;
      do begin
        @(posedge CLOCK);
        n++;
      end while (HREADYOUT !== 1'b1 && n < 64);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do begin
        @(posedge CLOCK);
        n++;
      end while (HREADYOUT !== 1'b1 && n < 64);
      if (n >= 64) begin
        bad_count++;
        report_and_stop();
      end
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  // Read: the expectation is queued, the monitor compares at completion
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    begin
      exp_q.push_back(e);
      bus(a, 1'b0, 32'h0);
    end
  endtask
  // Fire one reference edge, then log output edges for 400 cycles
  task automatic watch();
    begin
      r0 = 0;
      f0 = 0;
      r2 = 0;
      f2 = 0;
      dma_n = 0;
      rc = 0;
      fc = 0;
      low_len <= 8'($urandom_range(10, 3));
      fire <= 1'b1;
      for (int t = 1; t <= 400; t++) begin
        @(posedge CLOCK);
        fire <= 1'b0;
        if (DMA_REQ === 1'b1) dma_n++;
        if (OUT_AB[2] === 1'b1 && r2 == 0) r2 = t;
        if (OUT_AB[2] === 1'b0 && r2 != 0 && f2 == 0) f2 = t;
        if (OUT_AB[0] === 1'b1 && r0 == 0) r0 = t;
        if (OUT_AB[0] === 1'b0 && r0 != 0 && f0 == 0) f0 = t;
        if (OUT_CD[2] === 1'b1 && rc == 0) rc = t;
        if (OUT_CD[2] === 1'b0 && rc != 0 && fc == 0) fc = t;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Read monitor; wait states keep the data phase open
  always @(posedge CLOCK) begin
    if (rd_dph && HREADYOUT === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(HRDATA, exp_v)
    end
    if (HREADYOUT === 1'b1) begin
      rd_dph <= HSEL & HTRANS[1] & ~HWRITE;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6b0e1683));
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(12'h050, 32'hffff);
    rd(12'h04c, 32'h0);
    wr(12'h3fc, 32'h5a5a5a5a);
    rd(12'h3fc, 32'h0);
    rnd = $urandom();
    wr(12'h0b8, {16'h0, rnd[15:0]});
    rd(12'h0b8, {16'h0, rnd[15:0]});
    for (int i = 0; i < 15; i++) wr(cfg_a[i], {16'h0, cfg_d[i]});
    rd(12'h0ac, 32'h100);
    wr(12'h000, 32'h5);
    watch();
    `CHK(r0 - r2, 48)
    `CHK(f2 - r2, 64)
    `CHK(fc - rc, 32)
    `CHK(f0 - r0, 64)
    `CHK(dma_n, 1)
    `CHK(IRQ, 1'b1)
    rd(12'h054, 32'hb0);
    rd(12'h008, 32'hf07);
    wr(12'h00c, 32'h0);
    @(posedge CLOCK);
    `CHK(IRQ, 1'b0)
    wr(12'h00c, 32'h4);
    @(posedge CLOCK);
    `CHK(IRQ, 1'b1)
    wr(12'h008, 32'h4);
    wr(12'h048, 32'h1);
    @(posedge CLOCK);
    `CHK(IRQ, 1'b0)
    rd(12'h008, 32'hf03);
    watch();
    `CHK(r0, 0)
    `CHK(dma_n, 1)
    @(posedge CLOCK);
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule // ext_triggered_pulse_timer_bench
